// ===== hdl/sig_pkg.sv
package sig_pkg;

  // Board-relative I/O offsets (address bits 4:0)
  localparam logic [4:0] OFS_PAR_A  = 5'h10;
  localparam logic [4:0] OFS_PAR_B  = 5'h11;
  localparam logic [4:0] OFS_STAT   = 5'h12;
  localparam logic [4:0] OFS_IRESP  = 5'h13;
  localparam logic [4:0] OFS_ICTL_A = 5'h14;
  localparam logic [4:0] OFS_ICTL_B = 5'h15;
  localparam logic [1:0] OFS_CTL_HI = 2'h3;

  // Status register field positions
  localparam int STAT_TAKEN_A = 0;
  localparam int STAT_FULL_A  = 1;
  localparam int STAT_TAKEN_B = 2;
  localparam int STAT_FULL_B  = 3;

  // Controller reset hold after board reset
  localparam int CLK_PERIOD_PS = 5000;
  localparam int RST_HOLD_NS   = 100;
  localparam int RST_HOLD_CYC  = (RST_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef struct packed {
    logic       psync;
    logic       phi2;
    logic       pdbin;
    logic       pwr_n;
    logic       sinta;
    logic       sinp;
    logic       sout;
    logic [7:0] addr;
    logic [7:0] dout;
  } sig_bus_t;

  typedef struct packed {
    logic [1:0] stb;
    logic [1:0] accept;
    logic [7:0] a_data;
    logic [7:0] b_data;
    logic [3:0] aux_src;
    logic       ictl_wait;
    logic [7:0] ictl_rdata;
  } sig_per_t;

  typedef struct packed {
    logic [2:0]      base;
    logic [7:0]      polarity;
    logic [7:0][2:0] src_sel;
    logic            inta_resp;
    logic            one_wait;
  } sig_strap_t;

  typedef struct packed {
    sig_bus_t   bus;
    sig_per_t   per;
    sig_strap_t strap;
    logic [7:0] line;
    logic [7:0] sw;
  } sig_pin_t;

  typedef struct packed {
    logic [1:0][7:0] par_out;
    logic [1:0][7:0] par_in;
    logic [1:0]      taken;
    logic [1:0]      full;
    logic [7:0]      drv;
    logic [7:0]      line_oe;
    logic            wait_st;
    logic            inta_done;
    logic [7:0]      din;
    logic            din_oe;
    logic            prdy_oe;
    logic [1:0]      ictl_cs;
    logic            ictl_rd;
    logic            ictl_wr;
    logic            ictl_ack;
    logic            ictl_rst;
    logic [4:0]      rst_cnt;
    logic [7:0]      wdata;
    logic [7:0]      irq_a_n;
    logic [7:0]      irq_b_n;
    logic            pdbin_p;
    logic            pwr_p;
    logic            psync_p;
    logic            phi2_p;
    logic [1:0]      stb_p;
    logic [1:0]      acc_p;
  } sig_state_t;

  localparam sig_state_t SIG_STATE_RST = '{
    taken    : 2'h3,
    rst_cnt  : 5'(RST_HOLD_CYC),
    ictl_rst : 1'b1,
    irq_a_n  : 8'hFF,
    irq_b_n  : 8'hFF,
    pwr_p    : 1'b1,
    default  : '0
  };

endpackage : sig_pkg

// ===== hdl/sig_sync.sv
`timescale 1ns/10ps
module sig_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_srst,
  // Asynchronous in, filtered out
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  typedef struct packed {
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;
    logic [W-1:0] out;
  } sig_sync_st_t;

  sig_sync_st_t q;
  sig_sync_st_t d;

  // Output moves only once stages two and three agree; stage one feeds stage two only
  always_comb
  begin
    d     = q;
    d.ff1 = i_d;
    d.ff2 = q.ff1;
    d.ff3 = q.ff2;
    if (q.ff2 == q.ff3)
    begin
      d.out = q.ff3;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign o_q = q.out;

endmodule : sig_sync

// ===== hdl/sig_glue.sv
`timescale 1ns/10ps
module sig_glue
  import sig_pkg::*;
(
  // Clock and reset
  input  wire logic            i_clk,
  input  wire logic            i_srst,
  // Bus side
  input  wire sig_pkg::sig_bus_t   i_bus,
  output logic     [7:0]       o_din,
  output logic                 o_din_oe,
  output logic                 o_prdy_oe,
  // Peripheral, controller returns and straps
  input  wire sig_pkg::sig_per_t   i_per,
  input  wire sig_pkg::sig_strap_t i_strap,
  // Control lines
  input  wire logic [7:0]      i_ctl_line,
  input  wire logic [7:0]      i_line_drive_switch,
  output logic      [7:0]      o_ctl_line,
  output logic      [7:0]      o_ctl_line_oe,
  // Parallel outputs
  output logic      [7:0]      o_par_a_data,
  output logic      [7:0]      o_par_b_data,
  // Interrupt controller strobes and requests
  output logic      [1:0]      o_ictl_cs,
  output logic                 o_ictl_rd,
  output logic                 o_ictl_wr,
  output logic                 o_ictl_ack,
  output logic                 o_ictl_reset,
  output logic      [7:0]      o_ictl_wdata,
  output logic      [7:0]      o_irq_a_n,
  output logic      [7:0]      o_irq_b_n
);

  import sig_pkg::*;

  function automatic logic [1:0] par_hit(input logic [4:0] ofs);
    par_hit = {ofs == OFS_PAR_B, ofs == OFS_PAR_A};
  endfunction : par_hit

  function automatic logic ctl_hit(input logic [4:0] ofs);
    ctl_hit = (ofs[4:3] == OFS_CTL_HI);
  endfunction : ctl_hit

  sig_pin_t   pin_raw;
  sig_pin_t   s;
  sig_state_t q;
  sig_state_t d;
  logic       rd_rise;
  logic       rd_fall;
  logic       wr_fall;
  logic       psync_rise;
  logic       phi2_fall;
  logic [1:0] stb_rise;
  logic [1:0] acc_rise;
  logic       bsel;
  logic [4:0] ofs;
  logic       inta_on;
  logic       resp_rd;
  logic [7:0] src_vec;
  logic [1:0] par_sel;

  assign pin_raw = '{bus: i_bus, per: i_per, strap: i_strap,
                     line: i_ctl_line, sw: i_line_drive_switch};

  // Everything from the pins is filtered, data travels with its strobe
  sig_sync #(
    .W ($bits(sig_pin_t))
  ) u_sync (
    .i_clk  (i_clk),
    .i_srst (i_srst),
    .i_d    (pin_raw),
    .o_q    (s)
  );

  assign rd_rise    = s.bus.pdbin & ~q.pdbin_p;
  assign rd_fall    = ~s.bus.pdbin & q.pdbin_p;
  assign wr_fall    = ~s.bus.pwr_n & q.pwr_p;
  assign psync_rise = s.bus.psync & ~q.psync_p;
  assign phi2_fall  = ~s.bus.phi2 & q.phi2_p;
  assign stb_rise   = s.per.stb & ~q.stb_p;
  assign acc_rise   = s.per.accept & ~q.acc_p;
  assign ofs        = s.bus.addr[4:0];
  assign par_sel    = par_hit(ofs);
  assign bsel       = (s.bus.sinp | s.bus.sout) & (s.bus.addr[7:5] == s.strap.base);
  // Acknowledge path only when strapped for it, and only for the first byte
  assign inta_on    = s.bus.sinta & s.strap.inta_resp & ~q.inta_done;
  assign resp_rd    = bsel & (ofs == OFS_IRESP) & ~s.strap.inta_resp;
  assign src_vec    = {s.per.aux_src, q.full[1], q.taken[1], q.full[0], q.taken[0]};

  always_comb
  begin
    d = q;
    d.pdbin_p = s.bus.pdbin;
    d.pwr_p   = s.bus.pwr_n;
    d.psync_p = s.bus.psync;
    d.phi2_p  = s.bus.phi2;
    d.stb_p   = s.per.stb;
    d.acc_p   = s.per.accept;

    for (int i = 0; i < 2; i++)
    begin
      // Clear first so a simultaneous peripheral event wins
      if (wr_fall & bsel & par_sel[i])
      begin
        d.par_out[i] = s.bus.dout;
        d.taken[i]   = 1'b0;
      end
      if (acc_rise[i])
      begin
        d.taken[i] = 1'b1;
      end
      if (rd_fall & bsel & par_sel[i])
      begin
        d.full[i] = 1'b0;
      end
      if (stb_rise[i])
      begin
        d.par_in[i] = (i == 0) ? s.per.a_data : s.per.b_data;
        d.full[i]   = 1'b1;
      end
    end

    if (wr_fall & bsel & ctl_hit(ofs))
    begin
      d.drv[ofs[2:0]] = ~s.bus.dout[0];
    end
    d.line_oe = s.sw;

    // Set on PSYNC beats the clear, a new cycle must see its wait whenever one_wait is strapped
    if (psync_rise & s.strap.one_wait)
    begin
      d.wait_st = 1'b1;
    end
    else if (phi2_fall)
    begin
      d.wait_st = 1'b0;
    end

    if (psync_rise)
    begin
      d.inta_done = 1'b0;
    end
    else if (rd_fall & s.bus.sinta & s.strap.inta_resp)
    begin
      d.inta_done = 1'b1;
    end

    d.din = 8'h00;
    if (inta_on | resp_rd)
    begin
      d.din = s.per.ictl_rdata;
    end
    else if (ctl_hit(ofs))
    begin
      d.din[0] = ~s.line[ofs[2:0]];
    end
    else
    begin
      unique case (ofs)
        OFS_PAR_A:  d.din = q.par_in[0];
        OFS_PAR_B:  d.din = q.par_in[1];
        // Plain read of the flags, no side effect, top nibble zero
        OFS_STAT:   d.din = {4'h0, q.full[1], q.taken[1], q.full[0], q.taken[0]};
        OFS_ICTL_A,
        OFS_ICTL_B: d.din = s.per.ictl_rdata;
        default:    d.din = 8'h00;
      endcase
    end
    d.din_oe  = s.bus.pdbin & (bsel | inta_on);
    d.prdy_oe = (q.wait_st | s.per.ictl_wait) &
                (bsel | (s.bus.sinta & s.strap.inta_resp));

    d.ictl_cs  = {bsel & (ofs == OFS_ICTL_B), bsel & (ofs == OFS_ICTL_A)};
    d.ictl_rd  = s.bus.pdbin;
    d.ictl_wr  = ~s.bus.pwr_n;
    d.ictl_ack = s.bus.pdbin & (inta_on | resp_rd);
    d.wdata    = s.bus.dout;

    // Controllers stay in reset a while after the board leaves it
    if (q.rst_cnt != 5'h0)
    begin
      d.rst_cnt = q.rst_cnt - 5'h1;
    end
    d.ictl_rst = (q.rst_cnt != 5'h0);

    d.irq_a_n = ~(s.line ^ s.strap.polarity);
    for (int k = 0; k < 8; k++)
    begin
      d.irq_b_n[k] = ~src_vec[s.strap.src_sel[k]];
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      q <= SIG_STATE_RST;
    end
    else
    begin
      q <= d;
    end
  end

  assign o_din         = q.din;
  assign o_din_oe      = q.din_oe;
  assign o_prdy_oe     = q.prdy_oe;
  assign o_ctl_line    = q.drv;
  assign o_ctl_line_oe = q.line_oe;
  assign o_par_a_data  = q.par_out[0];
  assign o_par_b_data  = q.par_out[1];
  assign o_ictl_cs     = q.ictl_cs;
  assign o_ictl_rd     = q.ictl_rd;
  assign o_ictl_wr     = q.ictl_wr;
  assign o_ictl_ack    = q.ictl_ack;
  assign o_ictl_reset  = q.ictl_rst;
  assign o_ictl_wdata  = q.wdata;
  assign o_irq_a_n     = q.irq_a_n;
  assign o_irq_b_n     = q.irq_b_n;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  taken_clear_a: assert property (
    wr_fall && bsel && ofs == OFS_PAR_A && !acc_rise[0]
    |=> !q.taken[0] && q.par_out[0] == $past(s.bus.dout))
    else $error("output-taken A not cleared by port write");

  taken_set_b_a: assert property (
    acc_rise[1] |=> q.taken[1] ##1 (q.taken[1] || $past(wr_fall)))
    else $error("output-taken B not set by accept strobe");

  full_set_a: assert property (
    stb_rise[0] |=> q.full[0] && q.par_in[0] == $past(s.per.a_data))
    else $error("input-full A not set with latched byte");

  stat_upper_zero_a: assert property (
    bsel && ofs == OFS_STAT && !inta_on |=> q.din[7:4] == 4'h0)
    else $error("status upper nibble not zero");

  stat_no_side_a: assert property (
    bsel && ofs == OFS_STAT && rd_fall && stb_rise == 2'b00 && acc_rise == 2'b00
    && !wr_fall |=> $stable(q.full) && $stable(q.taken))
    else $error("status read changed a flag");

  ctl_write_a: assert property (
    wr_fall && bsel && ctl_hit(ofs) |=> ##1 o_ctl_line[$past(ofs[2:0], 2)] == ~$past(s.bus.dout[0], 2))
    else $error("control line driver not loaded with inverted bit 0");

  ctl_read_a: assert property (
    bsel && ctl_hit(ofs) && !inta_on && !resp_rd |=>
    o_din == {7'h0, ~$past(s.line[ofs[2:0]])})
    else $error("control line read not inverted level");

  din_drive_a: assert property (
    o_din_oe |-> $past(s.bus.pdbin) && $past(bsel || inta_on))
    else $error("data-in driven outside a qualified read");

  wait_clear_a: assert property (
    phi2_fall && !(psync_rise && s.strap.one_wait) |=> !q.wait_st)
    else $error("wait flop not cleared on Phi 2 fall");

  prdy_qual_a: assert property (
    o_prdy_oe |-> $past(bsel || (s.bus.sinta && s.strap.inta_resp)))
    else $error("PRDY pulled outside select or acknowledge");

  ack_route_a: assert property (
    s.bus.sinta && !s.strap.inta_resp && !resp_rd |=> !q.ictl_ack)
    else $error("sINTA acknowledged while response is by port");

  one_byte_a: assert property (
    rd_fall && s.bus.sinta && s.strap.inta_resp && !psync_rise |=> !inta_on)
    else $error("second acknowledge byte offered");

endmodule : sig_glue

// ===== test/sig_host.sv
`timescale 1ns/10ps
module sig_host (
  // Clock
  input  wire logic         i_clk,
  // Board answers
  input  wire logic [7:0]   i_din,
  input  wire logic         i_din_oe,
  input  wire logic         i_prdy_oe,
  // Bus pins
  output sig_pkg::sig_bus_t o_bus
);
  import sig_pkg::*;

  logic [3:0] ph_cnt;
  logic       seen_wait;

  initial
  begin
    o_bus       = '0;
    o_bus.pwr_n = 1'b1;
    ph_cnt      = 4'h0;
    seen_wait   = 1'b0;
  end

  // Phase clock 5 high 5 low, slow enough for the pin filter
  always @(posedge i_clk)
  begin
    ph_cnt     <= (ph_cnt == 4'h9) ? 4'h0 : ph_cnt + 4'h1;
    o_bus.phi2 <= (ph_cnt < 4'h5);
    if (i_prdy_oe)
      seen_wait <= 1'b1;
  end

  // kind = {sinta, sinp, sout}; strobe held until the board lets PRDY go
  task automatic cycle(input logic [2:0] kind, input logic [7:0] addr,
                       input logic [7:0] wdata, output logic [7:0] rdata,
                       output logic oe);
    int n;
    @(posedge i_clk) #1;
    o_bus.addr = addr;
    {o_bus.sinta, o_bus.sinp, o_bus.sout} = kind;
    o_bus.dout  = wdata;
    o_bus.psync = 1'b1;
    repeat (5) @(posedge i_clk);
    #1;
    o_bus.psync = 1'b0;
    o_bus.pdbin = ~kind[0];
    o_bus.pwr_n = ~kind[0];
    repeat (12) @(posedge i_clk);
    n = 0;
    while (i_prdy_oe && n < 40)
    begin
      @(posedge i_clk);
      n++;
    end
    rdata = i_din;
    oe    = i_din_oe;
    #1;
    o_bus.pdbin = 1'b0;
    o_bus.pwr_n = 1'b1;
    // Released data lines must not keep the last value
    o_bus.dout  = ~wdata;
    repeat (6) @(posedge i_clk);
    #1;
    {o_bus.sinta, o_bus.sinp, o_bus.sout} = 3'h0;
    o_bus.addr = ~addr;
    repeat (4) @(posedge i_clk);
  endtask : cycle
endmodule : sig_host

// ===== test/tb.sv
`timescale 1ns/10ps
module tb;
  import sig_pkg::*;

  localparam logic [2:0] BASE = 3'h2;

  logic       i_clk;
  logic       i_srst;
  sig_bus_t   bus;
  sig_per_t   per;
  sig_strap_t strap;
  logic [7:0] line;
  logic [7:0] sw;
  logic [7:0] din;
  logic       din_oe;
  logic       prdy_oe;
  logic [7:0] ctl_out;
  logic [7:0] ctl_oe;
  logic [7:0] par_a;
  logic [7:0] par_b;
  logic       ictl_rst;
  logic [7:0] irq_a_n;
  logic [7:0] irq_b_n;
  logic [1:0] ictl_cs;
  logic       ictl_rd;
  logic       ictl_wr;
  logic       ictl_ack;
  logic [7:0] ictl_wd;
  logic       ack_seen;
  logic       cs_seen;
  logic [7:0] wd_seen;
  logic [7:0] rdat;
  logic       roe;
  logic       wr;
  logic [4:0] ofs;
  logic [7:0] d;
  logic [7:0] e;
  int         num_errors;
  int         checks_done;

  // {write, offset, data, expected read}
  logic [21:0] rows [12] = '{
    {1'b0, OFS_STAT, 8'h00, 8'h05}, {1'b1, OFS_PAR_A, 8'h5A, 8'h00},
    {1'b0, OFS_STAT, 8'h00, 8'h04}, {1'b1, OFS_PAR_B, 8'hA5, 8'h00},
    {1'b0, OFS_STAT, 8'h00, 8'h00}, {1'b0, 5'h0F, 8'h00, 8'h00},
    {1'b1, 5'h18, 8'hFE, 8'h00}, {1'b1, 5'h19, 8'h01, 8'h00},
    {1'b0, 5'h18, 8'h00, 8'h01}, {1'b0, 5'h19, 8'h00, 8'h00},
    {1'b0, OFS_ICTL_A, 8'h00, 8'hC7}, {1'b1, OFS_ICTL_B, 8'h3E, 8'h00}};

  sig_glue dut (
    .i_clk(i_clk), .i_srst(i_srst), .i_bus(bus), .o_din(din), .o_din_oe(din_oe),
    .o_prdy_oe(prdy_oe), .i_per(per), .i_strap(strap), .i_ctl_line(line),
    .i_line_drive_switch(sw), .o_ctl_line(ctl_out), .o_ctl_line_oe(ctl_oe),
    .o_par_a_data(par_a), .o_par_b_data(par_b), .o_ictl_cs(ictl_cs), .o_ictl_rd(ictl_rd),
    .o_ictl_wr(ictl_wr), .o_ictl_ack(ictl_ack), .o_ictl_reset(ictl_rst),
    .o_ictl_wdata(ictl_wd), .o_irq_a_n(irq_a_n), .o_irq_b_n(irq_b_n));

  // Controller strobes only stand inside a cycle, so they are caught here
  always @(posedge i_clk)
  begin
    if (ictl_ack) ack_seen <= 1'b1;
    if (ictl_cs[0] && ictl_rd) cs_seen <= 1'b1;
    if (ictl_cs[1] && ictl_wr) wd_seen <= ictl_wd;
  end

  sig_host host (
    .i_clk(i_clk), .i_din(din), .i_din_oe(din_oe), .i_prdy_oe(prdy_oe), .o_bus(bus));

  initial i_clk = 1'b0;
  always #2.5 i_clk = ~i_clk;

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic op(input logic [2:0] kind, input logic [7:0] addr, input logic [7:0] wd);
    host.cycle(kind, addr, wd, rdat, roe);
  endtask : op

  task automatic end_sim;
    if (num_errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim

  initial
  begin
    #50us;
    num_errors++;
    end_sim();
  end

  initial
  begin
    num_errors  = 0;
    checks_done = 0;
    i_srst      = 1'b1;
    ack_seen    = 1'b0;
    cs_seen     = 1'b0;
    wd_seen     = 8'h00;
    per         = '0;
    per.a_data  = 8'h3C;
    per.ictl_rdata = 8'hC7;
    strap       = '0;
    strap.base  = BASE;
    strap.one_wait  = 1'b1;
    strap.inta_resp = 1'b1;
    line        = 8'h02;
    sw          = 8'h0F;
    repeat (16) @(posedge i_clk);
    #1;
    chk("irq a in reset", 8'hFF, irq_a_n);
    i_srst = 1'b0;
    repeat (10) @(posedge i_clk);
    #1;
    chk("ictl reset held", 8'h01, {7'h0, ictl_rst});
    repeat (20) @(posedge i_clk);
    #1;
    chk("ictl reset off", 8'h00, {7'h0, ictl_rst});
    chk("irq a level", 8'hFD, irq_a_n);
    chk("irq b level", 8'h00, irq_b_n);
    foreach (rows[i])
    begin
      {wr, ofs, d, e} = rows[i];
      op(wr ? 3'b001 : 3'b010, {BASE, ofs}, d);
      if (!wr)
      begin
        chk("row read", e, rdat);
        chk("row oe", 8'h01, {7'h0, roe});
      end
    end
    chk("par a out", 8'h5A, par_a);
    chk("par b out", 8'hA5, par_b);
    chk("ctl drivers", 8'h01, ctl_out);
    chk("ctl enables", 8'h0F, ctl_oe);
    chk("irq b taken", 8'hFF, irq_b_n);
    chk("ictl a read", 8'h01, {7'h0, cs_seen});
    chk("ictl b write", 8'h3E, wd_seen);
    chk("wait seen", 8'h01, {7'h0, host.seen_wait});
    // Peripheral accept on both ports, data strobe on A
    @(posedge i_clk) #1;
    per.accept = 2'b11;
    per.stb    = 2'b01;
    repeat (6) @(posedge i_clk);
    #1;
    per.accept = 2'b00;
    per.stb    = 2'b00;
    repeat (8) @(posedge i_clk);
    op(3'b010, {BASE, OFS_STAT}, 8'h00);
    chk("stat strobes", 8'h07, rdat);
    op(3'b010, {BASE, OFS_STAT}, 8'h00);
    chk("stat reread", 8'h07, rdat);
    op(3'b010, {BASE, OFS_PAR_A}, 8'h00);
    chk("par a in", 8'h3C, rdat);
    op(3'b010, {BASE, OFS_STAT}, 8'h00);
    chk("stat after read", 8'h05, rdat);
    host.seen_wait = 1'b0;
    op(3'b010, {~BASE, OFS_STAT}, 8'h00);
    chk("foreign oe", 8'h00, {7'h0, roe});
    chk("foreign wait", 8'h00, {7'h0, host.seen_wait});
    op(3'b100, 8'h00, 8'h00);
    chk("inta byte", 8'hC7, rdat);
    chk("inta oe", 8'h01, {7'h0, roe});
    chk("inta ack", 8'h01, {7'h0, ack_seen});
    strap.inta_resp = 1'b0;
    repeat (8) @(posedge i_clk);
    ack_seen = 1'b0;
    op(3'b100, 8'h00, 8'h00);
    chk("inta ignored", 8'h00, {7'h0, roe});
    chk("inta no ack", 8'h00, {7'h0, ack_seen});
    op(3'b010, {BASE, OFS_IRESP}, 8'h00);
    chk("resp port", 8'hC7, rdat);
    end_sim();
  end
endmodule : tb
